/* File: include/gpt_pkg.sv */
// package: register map, field positions, reset values and shared types of the timer
package gpt_pkg;
    // register byte offsets (apb word aligned)
    localparam logic [11:0] GPT_CFG_OFF = 12'h000;
    localparam logic [11:0] GPT_LMODE_OFF = 12'h004;
    localparam logic [11:0] GPT_HMODE_OFF = 12'h008;
    localparam logic [11:0] GPT_CTL_OFF = 12'h00C;
    localparam logic [11:0] GPT_IMR_OFF = 12'h018;
    localparam logic [11:0] GPT_RIS_OFF = 12'h01C;
    localparam logic [11:0] GPT_MIS_OFF = 12'h020;
    localparam logic [11:0] GPT_ICR_OFF = 12'h024;
    localparam logic [11:0] GPT_LLOAD_OFF = 12'h028;
    localparam logic [11:0] GPT_HLOAD_OFF = 12'h02C;
    localparam logic [11:0] GPT_LMATCH_OFF = 12'h030;
    localparam logic [11:0] GPT_LPRE_OFF = 12'h038;
    localparam logic [11:0] GPT_HPRE_OFF = 12'h03C;
    localparam logic [11:0] GPT_LCNT_OFF = 12'h048;
    localparam logic [11:0] GPT_HCNT_OFF = 12'h04C;
    // configuration encodings
    localparam logic [2:0] GPT_CFG_32_TIMER = 3'h0;
    localparam logic [2:0] GPT_CFG_32_RTC = 3'h1;
    // mode field encodings
    localparam logic [1:0] GPT_MODE_ONESHOT = 2'h1;
    localparam logic [1:0] GPT_MODE_PERIODIC = 2'h2;
    // control register bit positions
    localparam int GPT_CTL_EN = 0;
    localparam int GPT_CTL_STALL = 1;
    localparam int GPT_CTL_RTC_RUN_ENABLE = 4;
    localparam int GPT_CTL_OTE = 5;
    localparam int GPT_CTL_HSTALL = 9;
    // status bit positions
    localparam int GPT_ST_TO = 0;
    localparam int GPT_ST_RTC = 3;
    // reset values
    localparam logic [15:0] GPT_HALF_RST = 16'hFFFF;
    localparam logic [7:0] GPT_PRE_RST = 8'h00;
    localparam logic [31:0] GPT_RTC_START = 32'h0000_0001;
    // rtc divider: 32.768 khz reference edges per 1 hz tick
    localparam int GPT_REF_HZ = 32768;
    localparam int GPT_TICK_HZ = 1;
    localparam logic [15:0] GPT_RTC_DIV = 16'(GPT_REF_HZ / GPT_TICK_HZ);
    // apb request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } gpt_req_t;
    // status flag pair
    typedef struct packed {
        logic rtc;
        logic to;
    } gpt_flags_t;
endpackage

/* File: rtl/gpt_sync.sv */
// two-stage synchroniser for asynchronous inputs
module gpt_sync import gpt_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg; // first stage, read only by the second stage
    // two flops before any logic sees the level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule

/* File: rtl/gpt_timer.sv */
// general-purpose 32-bit timer: one-shot/periodic down-counter and rtc up-counter on apb
//
// Operation
// - reset leaves timer idle, controls cleared
// - reset loads both halves and loads with ones
// - reset clears both prescale registers
// - config 0 timer, config 1 rtc
// - 32-bit configs use halves as one timer
// - 32-bit load write fills both halves
// - 32-bit count read joins both halves
// - low mode field picks oneshot or periodic
// - enable starts down-count, reload after zero
// - oneshot stops and clears enable at zero
// - timeout raw flag held until cleared
// - masked timeout flag follows raw when enabled
// - adc trigger pulse at zero when enabled
// - load rewrite takes effect next cycle
// - stall bit freezes down-count during debug halt
// - rtc starts at one, then counts up on each 1 hz tick
// - rtc rolls to zero at match, continues
// - rtc match sets raw, masked flags; clear both
// - rtc never freezes during debug halt
//
// The placing of the registers and register access over APB were decided locally.
module gpt_timer import gpt_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic debug_halt,
    input wire logic capture_pin_0,
    output logic irq_out,
    output logic adc_trigger
);
    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [2:0] timer_config_reg; // configuration
    logic [1:0] low_half_mode_reg; // low half mode field
    logic [1:0] high_half_mode_reg; // high half mode field, unused in 32-bit
    logic [15:0] timer_control_reg; // control bits
    logic [15:0] low_interval_load; // low load half
    logic [15:0] high_interval_load; // high load half
    logic [31:0] low_match_value; // rtc match
    logic [7:0] low_prescale; // low prescale, storage only
    logic [7:0] high_prescale; // high prescale, storage only
    logic [31:0] count_reg; // joined counter halves
    logic [1:0] irq_mask_reg; // {rtc, timeout}
    gpt_flags_t raw_irq_status; // sticky raw flags
    logic [15:0] div_reg; // rtc reference divider
    logic rtc_armed_reg; // rtc start value already taken
    logic load_pend_reg; // interval load rewritten
    logic ref_sync; // synchronised reference clock
    logic ref_prev_reg; // previous reference level
    gpt_req_t req; // bus request this cycle
    gpt_flags_t masked_irq_status; // mask gated flags
    logic running; // counter enabled
    logic is_rtc; // rtc configuration
    logic stalled; // frozen by debug halt
    logic at_zero; // down-count reached zero
    logic ref_rise; // reference clock edge
    logic rtc_tick; // 1 hz tick
    logic rtc_hit; // rtc count equals match
    logic halt_sync; // synchronised debug halt

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    gpt_sync u_sync_ref (
        .pclk(pclk),
        .presetn(presetn),
        .d_in(capture_pin_0),
        .q_out(ref_sync)
    );
    gpt_sync u_sync_halt (
        .pclk(pclk),
        .presetn(presetn),
        .d_in(debug_halt),
        .q_out(halt_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode
    // an access is taken in the access phase; zero wait states
    always_comb begin
        req.wr = psel && penable && pwrite;
        req.rd = psel && penable && !pwrite;
        req.addr = paddr;
        req.wdata = pwdata;
    end

    assign is_rtc = (timer_config_reg == GPT_CFG_32_RTC);
    assign running = timer_control_reg[GPT_CTL_EN];
    // rtc never freezes; the stall applies to the down-counter only
    assign stalled = !is_rtc && halt_sync &&
        (timer_control_reg[GPT_CTL_STALL] || timer_control_reg[GPT_CTL_HSTALL]);
    assign at_zero = running && !is_rtc && !stalled && (count_reg == 32'h0000_0000);
    assign ref_rise = ref_sync && !ref_prev_reg;
    assign rtc_tick = ref_rise && (div_reg == GPT_RTC_DIV - 16'h0001);
    assign rtc_hit = running && is_rtc && rtc_tick && (count_reg == low_match_value);
    assign masked_irq_status = raw_irq_status & irq_mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: always ready, unmapped reads zero, no error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end
    // read data registered in the setup phase so it stands during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                GPT_CFG_OFF: prdata <= {29'h0000_0000, timer_config_reg};
                GPT_LMODE_OFF: prdata <= {30'h0000_0000, low_half_mode_reg};
                GPT_HMODE_OFF: prdata <= {30'h0000_0000, high_half_mode_reg};
                GPT_CTL_OFF: prdata <= {16'h0000, timer_control_reg};
                GPT_IMR_OFF: prdata <= {28'h0000_000, irq_mask_reg[1], 2'h0, irq_mask_reg[0]};
                GPT_RIS_OFF: prdata <= {28'h0000_000, raw_irq_status.rtc, 2'h0, raw_irq_status.to};
                GPT_MIS_OFF: prdata <= {28'h0000_000, masked_irq_status.rtc, 2'h0, masked_irq_status.to};
                GPT_LLOAD_OFF: prdata <= {high_interval_load, low_interval_load};
                GPT_HLOAD_OFF: prdata <= {16'h0000, high_interval_load};
                GPT_LMATCH_OFF: prdata <= low_match_value;
                GPT_LPRE_OFF: prdata <= {24'h00_0000, low_prescale};
                GPT_HPRE_OFF: prdata <= {24'h00_0000, high_prescale};
                GPT_LCNT_OFF: prdata <= count_reg;
                GPT_HCNT_OFF: prdata <= {16'h0000, count_reg[31:16]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and mode registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_config_reg <= 3'h0;
            low_half_mode_reg <= 2'h0;
            high_half_mode_reg <= 2'h0;
            irq_mask_reg <= 2'h0;
            low_match_value <= 32'hFFFF_FFFF;
            low_prescale <= GPT_PRE_RST;
            high_prescale <= GPT_PRE_RST;
        end else if (req.wr) begin
            case (req.addr)
                GPT_CFG_OFF: timer_config_reg <= req.wdata[2:0];
                GPT_LMODE_OFF: low_half_mode_reg <= req.wdata[1:0];
                GPT_HMODE_OFF: high_half_mode_reg <= req.wdata[1:0];
                GPT_IMR_OFF: irq_mask_reg <= {req.wdata[GPT_ST_RTC], req.wdata[GPT_ST_TO]};
                GPT_LMATCH_OFF: low_match_value <= req.wdata;
                GPT_LPRE_OFF: low_prescale <= req.wdata[7:0];
                GPT_HPRE_OFF: high_prescale <= req.wdata[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register; hardware clears enable at one-shot end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_reg <= 16'h0000;
        end else if (req.wr && req.addr == GPT_CTL_OFF) begin
            timer_control_reg <= req.wdata[15:0];
        end else if (at_zero && low_half_mode_reg == GPT_MODE_ONESHOT) begin
            timer_control_reg[GPT_CTL_EN] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interval load; a 32-bit write fills both halves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_interval_load <= GPT_HALF_RST;
            high_interval_load <= GPT_HALF_RST;
            load_pend_reg <= 1'b0;
        end else begin
            load_pend_reg <= 1'b0;
            if (req.wr && req.addr == GPT_LLOAD_OFF) begin
                low_interval_load <= req.wdata[15:0];
                high_interval_load <= req.wdata[31:16];
                load_pend_reg <= 1'b1;
            end else if (req.wr && req.addr == GPT_HLOAD_OFF) begin
                high_interval_load <= req.wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference divider and edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev_reg <= 1'b0;
            div_reg <= 16'h0000;
        end else begin
            ref_prev_reg <= ref_sync;
            if (!(is_rtc && running)) begin
                div_reg <= 16'h0000;
            end else if (ref_rise) begin
                div_reg <= rtc_tick ? 16'h0000 : div_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // the joined counter; halves act only as one 32-bit timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= {GPT_HALF_RST, GPT_HALF_RST};
            rtc_armed_reg <= 1'b0;
        end else if (is_rtc) begin
            if (!rtc_armed_reg) begin
                count_reg <= GPT_RTC_START;
                rtc_armed_reg <= 1'b1;
            end else if (rtc_hit) begin
                count_reg <= 32'h0000_0000;
            end else if (running && rtc_tick) begin
                count_reg <= count_reg + 32'h0000_0001;
            end
        end else begin
            rtc_armed_reg <= 1'b0; // next rtc selection starts at one again
            if (load_pend_reg) begin
                count_reg <= {high_interval_load, low_interval_load};
            end else if (at_zero) begin
                count_reg <= {high_interval_load, low_interval_load};
            end else if (running && !stalled) begin
                count_reg <= count_reg - 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky status; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_irq_status <= '0;
        end else begin
            if (at_zero) begin
                raw_irq_status.to <= 1'b1;
            end else if (req.wr && req.addr == GPT_ICR_OFF && req.wdata[GPT_ST_TO]) begin
                raw_irq_status.to <= 1'b0;
            end
            if (rtc_hit) begin
                raw_irq_status.rtc <= 1'b1;
            end else if (req.wr && req.addr == GPT_ICR_OFF && req.wdata[GPT_ST_RTC]) begin
                raw_irq_status.rtc <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and adc trigger outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
            adc_trigger <= 1'b0;
        end else begin
            irq_out <= |masked_irq_status;
            adc_trigger <= at_zero && timer_control_reg[GPT_CTL_OTE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    chk_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
        at_zero && low_half_mode_reg == GPT_MODE_ONESHOT && !(req.wr && req.addr == GPT_CTL_OFF)
        |=> !timer_control_reg[GPT_CTL_EN]) else $error("one-shot did not stop");
    chk_zero_reload: assert property (@(posedge pclk) disable iff (!presetn)
        at_zero && !load_pend_reg |=> count_reg == {$past(high_interval_load), $past(low_interval_load)})
        else $error("no reload after zero");
    chk_timeout_set: assert property (@(posedge pclk) disable iff (!presetn)
        at_zero |=> raw_irq_status.to) else $error("timeout flag not set");
    chk_timeout_hold: assert property (@(posedge pclk) disable iff (!presetn)
        raw_irq_status.to && !(req.wr && req.addr == GPT_ICR_OFF) |=> raw_irq_status.to)
        else $error("timeout flag lost");
    chk_adc_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        adc_trigger |-> $past(at_zero) && $past(timer_control_reg[GPT_CTL_OTE]))
        else $error("adc trigger without cause");
    chk_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq_out == $past(|masked_irq_status)) else $error("interrupt mismatch");
    chk_load_take: assert property (@(posedge pclk) disable iff (!presetn)
        load_pend_reg && !is_rtc |=> count_reg == {$past(high_interval_load), $past(low_interval_load)})
        else $error("load rewrite not taken");
    chk_stall_hold: assert property (@(posedge pclk) disable iff (!presetn)
        stalled && !load_pend_reg |=> $stable(count_reg)) else $error("counter moved while stalled");
    chk_rtc_roll: assert property (@(posedge pclk) disable iff (!presetn)
        rtc_hit && rtc_armed_reg |=> count_reg == 32'h0000_0000 && raw_irq_status.rtc)
        else $error("rtc did not roll over");
    chk_rtc_start: assert property (@(posedge pclk) disable iff (!presetn)
        is_rtc && !rtc_armed_reg |=> count_reg == GPT_RTC_START) else $error("rtc start not one");
    chk_rtc_nostall: assert property (@(posedge pclk) disable iff (!presetn)
        is_rtc |-> !stalled) else $error("rtc stalled");
    cov_oneshot: cover property (@(posedge pclk) disable iff (!presetn)
        at_zero && low_half_mode_reg == GPT_MODE_ONESHOT);
    cov_periodic: cover property (@(posedge pclk) disable iff (!presetn)
        at_zero ##[1:40] at_zero);
    cov_rtc_match: cover property (@(posedge pclk) disable iff (!presetn) rtc_hit);
    cov_stall: cover property (@(posedge pclk) disable iff (!presetn) stalled && running);
endmodule

/* File: tb/test_gp_timer_32bit_modes.sv */
// testbench: apb-driven self-checking bench of the 32-bit timer, rtc and status logic
module test_gp_timer_32bit_modes import gpt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // signals and bookkeeping
    logic pclk; // 200 mhz system clock
    logic presetn; // async reset, active low
    logic psel, penable, pwrite; // apb controls
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr;
    logic debug_halt; // debugger halt level
    logic capture_pin_0; // rtc reference input
    logic irq_out, adc_trigger;
    logic [31:0] exp_q[$]; // expected read data, oldest first
    int error_cnt = 0;
    int n_checks = 0;
    int adc_cnt = 0; // adc trigger pulses seen so far
    logic [31:0] rnd;
    logic ref_run; // reference clock runs only during the rtc test

    gpt_timer i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .debug_halt(debug_halt),
        .capture_pin_0(capture_pin_0),
        .irq_out(irq_out),
        .adc_trigger(adc_trigger)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, reference clock and output watchers
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = !pclk;
    end
    // stands still outside the rtc test; toggling each clock gives a rise every two
    always @(posedge pclk) begin
        if (ref_run) begin
            capture_pin_0 <= !capture_pin_0;
        end
    end
    always @(posedge pclk) begin
        if (adc_trigger) begin
            adc_cnt++;
        end
    end
    // read data taken at the edge where pready is sampled high
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("[FAIL] %0t read with no expectation", $time);
            end else begin
                chk_word(prdata, exp_q.pop_front(), "read data");
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks and verdict
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic results();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // apb master: setup, access until pready, then one idle edge
    task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic apb_read(input logic [11:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // limit: the rtc test needs about 66k cycles
    initial begin
        repeat (95000) @(posedge pclk);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    initial begin
        rnd = $urandom(28704);
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        debug_halt = 1'b0;
        capture_pin_0 = 1'b0;
        ref_run = 1'b0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset defaults
        apb_read(GPT_CFG_OFF, 32'h0000_0000);
        apb_read(GPT_CTL_OFF, 32'h0000_0000);
        apb_read(GPT_LLOAD_OFF, 32'hFFFF_FFFF);
        apb_read(GPT_LCNT_OFF, 32'hFFFF_FFFF);
        apb_read(GPT_LPRE_OFF, 32'h0000_0000);
        apb_read(GPT_HPRE_OFF, 32'h0000_0000);
        // joined load write and joined count read while stopped
        apb_write(GPT_LLOAD_OFF, 32'hABCD_1234);
        apb_read(GPT_HLOAD_OFF, 32'h0000_ABCD);
        apb_read(GPT_LCNT_OFF, 32'hABCD_1234);
        apb_read(GPT_HCNT_OFF, 32'h0000_ABCD);
        // one-shot with adc trigger and masked timeout
        rnd = 32'h0000_0005 + ($urandom % 16);
        apb_write(GPT_LLOAD_OFF, rnd);
        apb_write(GPT_LMODE_OFF, 32'h0000_0001);
        apb_write(GPT_IMR_OFF, 32'h0000_0001);
        apb_write(GPT_CTL_OFF, 32'h0000_0021);
        repeat (40) @(posedge pclk);
        chk_word(adc_cnt, 32'h0000_0001, "adc pulses");
        chk_bit(irq_out, 1'b1, "irq after timeout");
        apb_read(GPT_CTL_OFF, 32'h0000_0020);
        apb_read(GPT_RIS_OFF, 32'h0000_0001);
        apb_read(GPT_MIS_OFF, 32'h0000_0001);
        apb_read(GPT_LCNT_OFF, rnd);
        apb_write(GPT_ICR_OFF, 32'h0000_0001);
        apb_read(GPT_RIS_OFF, 32'h0000_0000);
        chk_bit(irq_out, 1'b0, "irq after clear");
        // periodic, stalled by debug halt, load rewrite while running
        debug_halt <= 1'b1;
        apb_write(GPT_LMODE_OFF, 32'h0000_0002);
        apb_write(GPT_CTL_OFF, 32'h0000_0003);
        apb_write(GPT_LLOAD_OFF, 32'h0000_0064);
        repeat (20) @(posedge pclk);
        apb_read(GPT_LCNT_OFF, 32'h0000_0064);
        debug_halt <= 1'b0;
        repeat (250) @(posedge pclk);
        apb_read(GPT_CTL_OFF, 32'h0000_0003);
        apb_read(GPT_RIS_OFF, 32'h0000_0001);
        chk_word(adc_cnt, 32'h0000_0001, "adc without enable");
        apb_write(GPT_CTL_OFF, 32'h0000_0000);
        apb_write(GPT_ICR_OFF, 32'h0000_0001);
        // rtc: starts at one, match at one rolls to zero, halt ignored
        apb_write(GPT_IMR_OFF, 32'h0000_0008);
        apb_write(GPT_CFG_OFF, 32'h0000_0001);
        apb_read(GPT_LCNT_OFF, 32'h0000_0001);
        apb_write(GPT_LMATCH_OFF, 32'h0000_0001);
        debug_halt <= 1'b1;
        apb_write(GPT_CTL_OFF, 32'h0000_0213);
        ref_run <= 1'b1;
        repeat (65600) @(posedge pclk);
        ref_run <= 1'b0;
        apb_read(GPT_RIS_OFF, 32'h0000_0008);
        apb_read(GPT_MIS_OFF, 32'h0000_0008);
        apb_read(GPT_LCNT_OFF, 32'h0000_0000);
        chk_bit(irq_out, 1'b1, "rtc irq");
        apb_write(GPT_ICR_OFF, 32'h0000_0008);
        apb_read(GPT_MIS_OFF, 32'h0000_0000);
        results();
    end
endmodule
